// *** logic/transceiver_id_mode_regs.sv ***
// Identification, scratch and mode-control register bank behind the serial port
//
// Behaviour
// - eight read-only part number bytes at offsets 0 to 7, last byte is variant
// - major die revision read-only at offset 8
// - minor die revision read-only at offset 9
// - five reserved bytes at offsets a to e read as zero
// - scratch byte at offset f reads back last write, resets to zero
// - mode-control at offset 10 resets to 04, standby
// - bit7 selective wake, bit6 timeout off, bit5 fault detect, 4-3 zero, 2-0 mode
// - selective wake bit works only on variants having it, else reserved zero
// - hardware may change hardware-updated fields independently of host writes
// - every field takes its reset value on device reset
// - array member address is group base plus index
// - mode codes 001 sleep, 100 standby, 101 listen, 111 normal, others reserved
// - mode field reads back the mode currently in effect
// - timeout-off bit set disables dominant timeout, clear keeps it enabled
`timescale 1ns/1ps
`include "transceiver_regs_defs.svh"

module transceiver_id_mode_regs #(
   parameter logic [63:0] PART_NUMBER = 64'h2122232425262728, // Arbitrary value
   parameter logic [7:0] MAJOR_REVISION = 8'h0a, // Arbitrary value
   parameter logic [7:0] MINOR_REVISION = 8'h0b, // Arbitrary value
   parameter bit HAS_SELECTIVE_WAKE = 1'b1,
   parameter bit HAS_FAULT_DETECT = 1'b1
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire transceiver_regs_pkg::reg_req_t req,
   output logic [7:0] rdata,
   output logic rvalid,
   input wire logic hw_mode_valid,
   input wire logic [2:0] hw_mode,
   output transceiver_regs_pkg::feature_ctrl_t features,
   output logic dominant_timeout_en,
   output logic [2:0] mode_request,
   output logic [2:0] mode_current
);
   logic [7:0] scratch_reg;
   logic [7:0] scratch_next;
   transceiver_regs_pkg::feature_ctrl_t features_reg;
   transceiver_regs_pkg::feature_ctrl_t features_next;
   logic [2:0] mode_req_reg;
   logic [2:0] mode_req_next;
   logic [2:0] mode_cur_reg;
   logic [2:0] mode_cur_next;
   logic [7:0] rdata_reg;
   logic rvalid_reg;

   // Address decode
   wire id_hit = (req.addr < (`PART_NUMBER_BASE + 7'(`PART_NUMBER_COUNT)));
   wire [6:0] id_offset = req.addr - `PART_NUMBER_BASE;
   wire [2:0] id_index = id_offset[2:0];
   wire rsvd_hit = (req.addr >= `RESERVED_CFG_BASE) &&
      (req.addr < (`RESERVED_CFG_BASE + 7'(`RESERVED_CFG_COUNT)));
   wire scratch_wr = req.wr_en && (req.addr == `SCRATCH_ADDR);
   wire mode_wr = req.wr_en && (req.addr == `MODE_CTRL_ADDR);
   wire [2:0] wr_mode = req.wdata[`MODE_SEL_MSB:`MODE_SEL_LSB];
   wire wr_mode_legal = (wr_mode == `MODE_SLEEP) || (wr_mode == `MODE_STANDBY) ||
      (wr_mode == `MODE_LISTEN) || (wr_mode == `MODE_NORMAL);

   // Part number byte y sits at bit lane 7-y of the parameter
   wire [7:0] part_number_byte = PART_NUMBER[8'(7 - id_index) * 8 +: 8];

   // Mode-control readback shows the mode in effect
   wire [7:0] mode_ctrl_rd = {features_reg.selective_wake_on,
      features_reg.dominant_timeout_off, features_reg.bus_fault_detect_on,
      2'b00, mode_cur_reg};

   // Read multiplexer, unmapped and reserved read zero
   wire [7:0] rd_mux =
      id_hit ? part_number_byte :
      (req.addr == `MAJOR_REV_ADDR) ? MAJOR_REVISION :
      (req.addr == `MINOR_REV_ADDR) ? MINOR_REVISION :
      rsvd_hit ? `RESERVED_CFG_RESET :
      (req.addr == `SCRATCH_ADDR) ? scratch_reg :
      (req.addr == `MODE_CTRL_ADDR) ? mode_ctrl_rd : 8'h00;

   // Writable state next values; writes elsewhere have no target
   assign scratch_next = scratch_wr ? req.wdata : scratch_reg;
   assign features_next.selective_wake_on = mode_wr ?
      (HAS_SELECTIVE_WAKE & req.wdata[`SEL_WAKE_BIT]) :
      features_reg.selective_wake_on;
   assign features_next.dominant_timeout_off = mode_wr ?
      req.wdata[`DTO_OFF_BIT] : features_reg.dominant_timeout_off;
   assign features_next.bus_fault_detect_on = mode_wr ?
      (HAS_FAULT_DETECT & req.wdata[`FAULT_DET_BIT]) :
      features_reg.bus_fault_detect_on;
   assign mode_req_next = (mode_wr && wr_mode_legal) ? wr_mode : mode_req_reg;
   // Hardware report of the mode wins over a host write in the same cycle
   assign mode_cur_next = hw_mode_valid ? hw_mode :
      (mode_wr && wr_mode_legal) ? wr_mode : mode_cur_reg;

   // Host-writable registers
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         scratch_reg <= `SCRATCH_RESET;
         features_reg <= '0;
         mode_req_reg <= 3'(`MODE_CTRL_RESET);
         mode_cur_reg <= `MODE_STANDBY;
      end else begin
         scratch_reg <= scratch_next;
         features_reg <= features_next;
         mode_req_reg <= mode_req_next;
         mode_cur_reg <= mode_cur_next;
      end
   end

   // Registered read data, one cycle after the read strobe
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rdata_reg <= 8'h00;
         rvalid_reg <= 1'b0;
      end else begin
         rvalid_reg <= req.rd_en;
         if (req.rd_en) begin
            rdata_reg <= rd_mux;
         end
      end
   end

   assign rdata = rdata_reg;
   assign rvalid = rvalid_reg;
   assign features = features_reg;
   assign dominant_timeout_en = ~features_reg.dominant_timeout_off;
   assign mode_request = mode_req_reg;
   assign mode_current = mode_cur_reg;

   // Checks
   sequence scratch_write_s;
      req.wr_en && req.addr == `SCRATCH_ADDR;
   endsequence

   scratch_readback_a: assert property (@(posedge clk) disable iff (!rst_n)
      scratch_write_s ##1 (req.rd_en && req.addr == `SCRATCH_ADDR && !req.wr_en)
      |=> rdata == $past(req.wdata, 2)) else $error("scratch readback mismatch");
   id_byte_read_a: assert property (@(posedge clk) disable iff (!rst_n)
      (req.rd_en && req.addr == 7'h07) |=> rdata == PART_NUMBER[7:0])
      else $error("last part number byte wrong");
   major_rev_read_a: assert property (@(posedge clk) disable iff (!rst_n)
      (req.rd_en && req.addr == `MAJOR_REV_ADDR) |=> rdata == MAJOR_REVISION)
      else $error("major revision wrong");
   minor_rev_read_a: assert property (@(posedge clk) disable iff (!rst_n)
      (req.rd_en && req.addr == `MINOR_REV_ADDR) |=> rdata == MINOR_REVISION)
      else $error("minor revision wrong");
   reserved_zero_a: assert property (@(posedge clk) disable iff (!rst_n)
      (req.rd_en && req.addr >= 7'h0a && req.addr <= 7'h0e) |=> rdata == 8'h00)
      else $error("reserved byte not zero");
   mode_bits_zero_a: assert property (@(posedge clk) disable iff (!rst_n)
      (req.rd_en && req.addr == `MODE_CTRL_ADDR) |=> rdata[4:3] == 2'b00)
      else $error("mode reserved bits set");
   mode_legal_a: assert property (@(posedge clk) disable iff (!rst_n)
      (mode_wr && !wr_mode_legal) |=> $stable(mode_request))
      else $error("reserved mode code accepted");
   mode_effect_a: assert property (@(posedge clk) disable iff (!rst_n)
      (req.rd_en && req.addr == `MODE_CTRL_ADDR) |=> rdata[2:0] == $past(mode_cur_reg))
      else $error("mode readback not current mode");
   hw_mode_wins_a: assert property (@(posedge clk) disable iff (!rst_n)
      hw_mode_valid |=> mode_current == $past(hw_mode))
      else $error("hardware mode update lost");
   timeout_ctrl_a: assert property (@(posedge clk) disable iff (!rst_n)
      (mode_wr && req.wdata[6]) |=> !dominant_timeout_en)
      else $error("timeout not disabled");
   sel_wake_gate_a: assert property (@(posedge clk) disable iff (!rst_n)
      !HAS_SELECTIVE_WAKE |-> !features.selective_wake_on)
      else $error("selective wake on without support");
   reset_mode_a: assert property (@(posedge clk)
      $rose(rst_n) |-> mode_current == 3'b100 && features == '0)
      else $error("mode reset value wrong");

   // Mode field tracking between hardware reports
   sequence legal_mode_write_s;
      mode_wr && wr_mode_legal && !hw_mode_valid;
   endsequence

   sequence mode_idle_s;
      !hw_mode_valid && !(mode_wr && wr_mode_legal);
   endsequence

   mode_follow_a: assert property (@(posedge clk) disable iff (!rst_n)
      legal_mode_write_s |=> mode_current == $past(wr_mode) &&
      mode_request == $past(wr_mode))
      else $error("legal mode write not applied");
   mode_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
      mode_idle_s |=> $stable(mode_current))
      else $error("mode changed without a cause");
   request_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
      !(mode_wr && wr_mode_legal) |=> $stable(mode_request))
      else $error("mode request changed without a legal write");
   rsvd_mode_keep_a: assert property (@(posedge clk) disable iff (!rst_n)
      (mode_wr && !wr_mode_legal && !hw_mode_valid) |=> $stable(mode_current))
      else $error("reserved mode code took effect");

   // Scratch and identification contents
   scratch_write_a: assert property (@(posedge clk) disable iff (!rst_n)
      scratch_wr |=> scratch_reg == $past(req.wdata))
      else $error("scratch write lost");
   scratch_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
      !scratch_wr |=> $stable(scratch_reg))
      else $error("scratch changed without a write");
   id_first_byte_a: assert property (@(posedge clk) disable iff (!rst_n)
      (req.rd_en && req.addr == `PART_NUMBER_BASE) |=> rdata == PART_NUMBER[63:56])
      else $error("first part number byte wrong");

   // Reset values seen at the first edge after release
   reset_scratch_a: assert property (@(posedge clk)
      $rose(rst_n) |-> scratch_reg == `SCRATCH_RESET && !rvalid)
      else $error("scratch or read valid reset value wrong");
   reset_request_a: assert property (@(posedge clk)
      $rose(rst_n) |-> mode_request == `MODE_STANDBY && dominant_timeout_en)
      else $error("mode request reset value wrong");

   // Feature bits against the variant and the host write
   fault_gate_a: assert property (@(posedge clk) disable iff (!rst_n)
      !HAS_FAULT_DETECT |-> !features.bus_fault_detect_on)
      else $error("fault detect on without support");
   timeout_keep_a: assert property (@(posedge clk) disable iff (!rst_n)
      (mode_wr && !req.wdata[`DTO_OFF_BIT]) |=> dominant_timeout_en)
      else $error("timeout not kept enabled");
   sel_wake_write_a: assert property (@(posedge clk) disable iff (!rst_n)
      (mode_wr && HAS_SELECTIVE_WAKE) |=>
      features.selective_wake_on == $past(req.wdata[`SEL_WAKE_BIT]))
      else $error("selective wake write lost");
endmodule : transceiver_id_mode_regs

// *** logic/transceiver_regs_defs.svh ***
// Offsets, field positions, reset values for the transceiver id/mode register bank
`ifndef TRANSCEIVER_REGS_DEFS_SVH
`define TRANSCEIVER_REGS_DEFS_SVH
`define ADDR_W 7
`define PART_NUMBER_BASE 7'h00
`define PART_NUMBER_COUNT 8
`define MAJOR_REV_ADDR 7'h08
`define MINOR_REV_ADDR 7'h09
`define RESERVED_CFG_BASE 7'h0a
`define RESERVED_CFG_COUNT 5
`define SCRATCH_ADDR 7'h0f
`define MODE_CTRL_ADDR 7'h10
`define SCRATCH_RESET 8'h00
`define RESERVED_CFG_RESET 8'h00
`define MODE_CTRL_RESET 8'h04
`define SEL_WAKE_BIT 7
`define DTO_OFF_BIT 6
`define FAULT_DET_BIT 5
`define MODE_SEL_MSB 2
`define MODE_SEL_LSB 0
`define MODE_SLEEP 3'h1
`define MODE_STANDBY 3'h4
`define MODE_LISTEN 3'h5
`define MODE_NORMAL 3'h7
`endif

// *** logic/transceiver_regs_pkg.sv ***
// Types shared by the transceiver id/mode register bank
package transceiver_regs_pkg;
   typedef enum logic [2:0] {
      MODE_SLEEP_E = 3'b001,
      MODE_STANDBY_E = 3'b100,
      MODE_LISTEN_E = 3'b101,
      MODE_NORMAL_E = 3'b111
   } op_mode_t;

   typedef struct packed {
      logic selective_wake_on;
      logic dominant_timeout_off;
      logic bus_fault_detect_on;
   } feature_ctrl_t;

   typedef struct packed {
      logic wr_en;
      logic rd_en;
      logic [6:0] addr;
      logic [7:0] wdata;
   } reg_req_t;
endpackage : transceiver_regs_pkg

// *** verification/reg_host_model.sv ***
// Host-side model issuing one register strobe per byte
`timescale 1ns/1ps
module reg_host_model (
   input wire logic clk,
   output transceiver_regs_pkg::reg_req_t req,
   input wire logic [7:0] rdata,
   input wire logic rvalid
);
   initial req = '{1'b0, 1'b0, 7'h55, 8'haa};
   // Released lines flip to the inverse so stale values never pass
   task automatic drop(input logic [6:0] a, input logic [7:0] d);
      @(posedge clk);
      req <= '{1'b0, 1'b0, ~a, ~d};
   endtask : drop
   task automatic wr(input logic [6:0] a, input logic [7:0] d);
      @(posedge clk);
      req <= '{1'b1, 1'b0, a, d};
      drop(a, d);
   endtask : wr
   // Data and valid taken one cycle after the read strobe
   task automatic rd(input logic [6:0] a, output logic [7:0] d, output logic v);
      @(posedge clk);
      req <= '{1'b0, 1'b1, a, 8'h00};
      drop(a, 8'h00);
      #1 d = rdata;
      v = rvalid;
   endtask : rd
   // Write then read the same offset on the very next edge
   task automatic wr_rd(input logic [6:0] a, input logic [7:0] wd, output logic [7:0] d,
      output logic v);
      @(posedge clk);
      req <= '{1'b1, 1'b0, a, wd};
      rd(a, d, v);
   endtask : wr_rd
endmodule : reg_host_model

// *** verification/tb.sv ***
// Self-checking bench for the id, scratch and mode-control register bank
`timescale 1ns/1ps
module tb;
   localparam logic [63:0] PN = 64'h6a6b6c6d7071727a; // Arbitrary value
   localparam logic [7:0] MAJ = 8'h2c; // Arbitrary value
   localparam logic [7:0] MIN = 8'h2d; // Arbitrary value
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic hw_mode_valid = 1'b0;
   logic [2:0] hw_mode = 3'h4;
   logic [7:0] rdata, d;
   logic rvalid, v, dominant_timeout_en;
   logic [2:0] mode_request, mode_current;
   transceiver_regs_pkg::reg_req_t req;
   transceiver_regs_pkg::feature_ctrl_t features;
   int n_errors = 0;
   int checks = 0;
   logic [2:0] codes [4] = '{3'h1, 3'h4, 3'h5, 3'h7};
   always #2 clk = ~clk;
   transceiver_id_mode_regs #(.PART_NUMBER(PN), .MAJOR_REVISION(MAJ),
      .MINOR_REVISION(MIN)) dut_u (.clk(clk), .rst_n(rst_n), .req(req),
      .rdata(rdata), .rvalid(rvalid), .hw_mode_valid(hw_mode_valid), .hw_mode(hw_mode),
      .features(features), .dominant_timeout_en(dominant_timeout_en),
      .mode_request(mode_request), .mode_current(mode_current));
   reg_host_model host_u (.clk(clk), .req(req), .rdata(rdata), .rvalid(rvalid));
   task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
      checks++;
      if (seen !== exp) begin
         n_errors++;
         $display("[ERR] %s expected %h seen %h", name, exp, seen);
      end
   endtask : check
   // Read one byte, compare data and the valid pulse
   task automatic rdc(input logic [6:0] a, input logic [7:0] exp);
      host_u.rd(a, d, v);
      check("rvalid", {7'h00, v}, 8'h01);
      check($sformatf("reg %h", a), d, exp);
   endtask : rdc
   // Reset contents of offsets 0 to f
   function automatic logic [7:0] id_byte(input logic [6:0] a);
      if (a < 7'h08) return PN[63 - 8 * a -: 8];
      return a == 7'h08 ? MAJ : a == 7'h09 ? MIN : 8'h00;
   endfunction : id_byte
   task automatic report_and_stop();
      $display("checks %0d errors %0d", checks, n_errors);
      if (n_errors == 0 && checks > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask : report_and_stop
   // Watchdog
   initial begin
      #20000;
      n_errors++;
      report_and_stop();
   end
   // Main sequence
   initial begin
      repeat (5) @(posedge clk);
      rst_n <= 1'b1;
      for (int a = 0; a < 16; a++) rdc(a[6:0], id_byte(a[6:0]));
      rdc(7'h10, 8'h04);
      for (int a = 0; a < 15; a++) host_u.wr(a[6:0], 8'hff);
      for (int a = 0; a < 15; a++) rdc(a[6:0], id_byte(a[6:0]));
      host_u.wr(7'h0f, 8'ha5);
      rdc(7'h0f, 8'ha5);
      host_u.wr(7'h0f, 8'h5a);
      rdc(7'h0f, 8'h5a);
      host_u.wr_rd(7'h0f, 8'hc3, d, v);
      check("scratch back to back", d, 8'hc3);
      rdc(7'h20, 8'h00);
      foreach (codes[i]) begin
         host_u.wr(7'h10, {5'h1f, codes[i]});
         rdc(7'h10, {5'h1c, codes[i]});
         check("mode_request", {5'h00, mode_request}, {5'h00, codes[i]});
         check("features", {5'h00, features}, 8'h07);
         check("dto_en", {7'h00, dominant_timeout_en}, 8'h00);
      end
      host_u.wr(7'h10, 8'h02);
      rdc(7'h10, 8'h07);
      check("dto_en", {7'h00, dominant_timeout_en}, 8'h01);
      // Hardware report and host mode write taken at the same edge
      fork
         host_u.wr(7'h10, 8'h04);
         begin
            @(posedge clk);
            hw_mode <= 3'h1;
            hw_mode_valid <= 1'b1;
            @(posedge clk);
            hw_mode_valid <= 1'b0;
         end
      join
      rdc(7'h10, 8'h01);
      check("mode_request", {5'h00, mode_request}, 8'h04);
      @(posedge clk);
      hw_mode <= 3'h5;
      hw_mode_valid <= 1'b1;
      @(posedge clk);
      hw_mode_valid <= 1'b0;
      rdc(7'h10, 8'h05);
      check("mode_current", {5'h00, mode_current}, 8'h05);
      host_u.wr(7'h0f, 8'h3c);
      rdc(7'h0f, 8'h3c);
      @(posedge clk);
      rst_n <= 1'b0;
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      rdc(7'h0f, 8'h00);
      rdc(7'h10, 8'h04);
      check("dto_en", {7'h00, dominant_timeout_en}, 8'h01);
      report_and_stop();
   end
endmodule : tb
